// ===== inc/scb_defines.svh
// constants for the serial bus control and status block
//
// Overview of operation
// - master bit sets on a generated start, clears on generated stop or lost arbitration
// - transmit bit sets on start or early data write, clears on start, loss, no write
// - writing start flag as master starts or repeats a start; zero clears the flag
// - start flag sets on received start plus address; only software clears it
// - stop flag as master sends stop after an ack cycle since the last start, then clears itself
// - stop flag sets on stop seen as addressed slave or loss by stop
// - stop flag reads one when slave stop seen or master stop pending
// - ack request sets when a byte is received, clears after each ack cycle
// - arbitration lost sets on unwanted repeated start as master with start flag low
// - arbitration lost sets when clock is low during stop or repeated start
// - arbitration lost sets when data line is low while driving one, not ack
// - arbitration lost clears whenever the interrupt flag is cleared
// - ack bit captures incoming ack, and software writes outgoing ack value
// - interrupt flag sets on start made, loss, byte done, address, stop received
// - while interrupt flag is set the clock line is held low
// - writing zero clears the interrupt flag, writing one forces it
// - master, transmit, ack request and arbitration bits ignore software writes
// - register is bit addressable at 0xC0 on page 0x00, resets to zero
// - start and stop both set as master gives stop then start
// - interrupt cleared without ack write after a received byte sends a nack
// - start flag stays set after the requested start is made
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH

`define SCB_CTRL_ADDR 8'hC0
`define SCB_CTRL_PAGE 8'h00
`define SCB_CTRL_RESET 8'h00
`define SCB_BIT_MASTER 7
`define SCB_BIT_TRANSMIT_DIRECTION_FLAG 6
`define SCB_BIT_START 5
`define SCB_BIT_STOP 4
`define SCB_BIT_ACKNOWLEDGE_REQUEST_FLAG 3
`define SCB_BIT_ARBITRATION_LOST_FLAG 2
`define SCB_BIT_ACK 1
`define SCB_BIT_INT 0
`define SCB_CLK_NS 5
`define SCB_T_HALF_NS 5000
`define SCB_HALF_CYC ((`SCB_T_HALF_NS + `SCB_CLK_NS - 1) / `SCB_CLK_NS)

`endif

// ===== inc/scb_pkg.sv
// types of the serial bus control and status block
`default_nettype none
package scb_pkg;
  typedef enum logic [2:0] {
    G_IDLE, G_START_HOLD, G_STOP_LOW, G_STOP_SETUP, G_STOP_REL, G_RS_REL, G_RS_SCL
  } scb_gen_e;
endpackage
`default_nettype wire

// ===== logic/scb_ctrl.sv
// serial bus control and status register with start and stop generation
`include "scb_defines.svh"
`default_nettype none
module scb_ctrl (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [7:0] PAGE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] BIT_ADDR,
  input wire logic BIT_VAL,
  input wire logic BIT_WR,
  output logic [7:0] RDATA,
  // shift engine side
  input wire logic DATA_WR,
  input wire logic FRAME_START,
  input wire logic BYTE_TX_DONE,
  input wire logic ACK_IN,
  input wire logic BYTE_RX_DONE,
  input wire logic ADDR_MATCH,
  input wire logic ACK_CYCLE_DONE,
  input wire logic SDA_DRIVE_ONE,
  input wire logic SHIFT_SDA_LOW,
  input wire logic SHIFT_SCL_LOW,
  output logic [7:0] STATUS,
  // bus pins
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE
);

  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] prev_q;
  logic sda_s;
  logic scl_s;
  logic start_det;
  logic stop_det;
  logic master_q;
  logic transmit_direction_flag_q;
  logic sta_q;
  logic sto_q;
  logic acknowledge_request_flag_q;
  logic arbitration_lost_flag_q;
  logic ack_q;
  logic si_q;
  logic busy_q;
  logic addressed_q;
  logic ack_seen_q;
  logic data_wr_seen_q;
  logic [7:0] rdata_q;
  logic sda_oe_q;
  logic scl_oe_q;
  logic [7:0] sw_mask;
  logic [7:0] sw_val;
  scb_pkg::scb_gen_e gen_q;
  scb_pkg::scb_gen_e gen_d;
  logic [10:0] cnt_q;
  logic done;
  logic sda_drv;
  logic scl_drv;
  logic gen_idle;
  logic start_gen_ev;
  logic stop_gen_ev;
  logic ext_start;
  logic own_stop;
  logic slv_stop_ev;
  logic arb_ev;
  logic arb_stop_ev;
  logic hw_si;
  logic si_clr;

  // two flops on each pin before any logic looks at it
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          sync1_q[i] <= 1'b1;
          sync2_q[i] <= 1'b1;
          prev_q[i] <= 1'b1;
        end else begin
          sync1_q[i] <= (i == 0) ? SDA_I : SCL_I;
          sync2_q[i] <= sync1_q[i];
          prev_q[i] <= sync2_q[i];
        end
      end
    end
  endgenerate

  // line conditions from the settled samples
  assign sda_s = sync2_q[0];
  assign scl_s = sync2_q[1];
  assign start_det = scl_s && prev_q[1] && prev_q[0] && !sda_s;
  assign stop_det = scl_s && prev_q[1] && !prev_q[0] && sda_s;
  assign gen_idle = (gen_q == scb_pkg::G_IDLE);
  assign done = (cnt_q == 11'(`SCB_HALF_CYC - 1));

  // software write, byte wide or a single bit
  always_comb begin
    sw_mask = 8'h00;
    sw_val = WDATA;
    if (WR && PAGE == `SCB_CTRL_PAGE && ADDR == `SCB_CTRL_ADDR) begin
      sw_mask = 8'hFF;
    end else if (BIT_WR && PAGE == `SCB_CTRL_PAGE
        && BIT_ADDR[7:3] == 5'(`SCB_CTRL_ADDR >> 3)) begin
      sw_mask = 8'h01 << BIT_ADDR[2:0];
      sw_val = {8{BIT_VAL}};
    end
  end

  // events seen on the bus or made here
  assign start_gen_ev = (gen_q == scb_pkg::G_START_HOLD) && done;
  assign stop_gen_ev = (gen_q == scb_pkg::G_STOP_REL) && done;
  assign own_stop = (gen_q == scb_pkg::G_STOP_REL);
  assign ext_start = start_det && gen_idle;
  assign slv_stop_ev = stop_det && !own_stop && addressed_q && !master_q;
  assign arb_stop_ev = stop_det && !own_stop && master_q;
  // lost arbitration, any of the four causes
  assign arb_ev = (ext_start && master_q && !sta_q)
    || (done && !scl_s && (gen_q == scb_pkg::G_STOP_SETUP
      || gen_q == scb_pkg::G_RS_SCL))
    || (gen_idle && SDA_DRIVE_ONE && scl_s && !sda_s)
    || arb_stop_ev;
  assign hw_si = start_gen_ev || arb_ev || BYTE_TX_DONE || BYTE_RX_DONE
    || ADDR_MATCH || slv_stop_ev;
  assign si_clr = sw_mask[`SCB_BIT_INT] && !sw_val[`SCB_BIT_INT] && !hw_si && si_q;

  // interrupt flag; a hardware event wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      si_q <= 1'b0;
    end else if (hw_si) begin
      si_q <= 1'b1;
    end else if (sw_mask[`SCB_BIT_INT]) begin
      si_q <= sw_val[`SCB_BIT_INT];
    end
  end

  // arbitration lost, read only, dropped when the flag is cleared
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      arbitration_lost_flag_q <= 1'b0;
    end else if (arb_ev) begin
      arbitration_lost_flag_q <= 1'b1;
    end else if (si_clr) begin
      arbitration_lost_flag_q <= 1'b0;
    end
  end

  // master role, no software path
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      master_q <= 1'b0;
    end else if (start_gen_ev) begin
      master_q <= 1'b1;
    end else if (stop_gen_ev || arb_ev) begin
      master_q <= 1'b0;
    end
  end

  // transmit direction, decided at each frame start
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      transmit_direction_flag_q <= 1'b0;
    end else if (start_gen_ev) begin
      transmit_direction_flag_q <= 1'b1;
    end else if (ext_start || arb_ev) begin
      transmit_direction_flag_q <= 1'b0;
    end else if (FRAME_START) begin
      transmit_direction_flag_q <= data_wr_seen_q || DATA_WR;
    end
  end

  // data register write remembered until the frame begins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      data_wr_seen_q <= 1'b0;
    end else if (FRAME_START) begin
      data_wr_seen_q <= 1'b0;
    end else if (DATA_WR) begin
      data_wr_seen_q <= 1'b1;
    end
  end

  // start flag; hardware only ever sets it, even after our own start
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sta_q <= 1'b0;
    end else if (ADDR_MATCH) begin
      sta_q <= 1'b1;
    end else if (sw_mask[`SCB_BIT_START]) begin
      sta_q <= sw_val[`SCB_BIT_START];
    end
  end

  // stop flag: request as master, report as slave
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sto_q <= 1'b0;
    end else if (slv_stop_ev || arb_stop_ev) begin
      sto_q <= 1'b1;
    end else if (stop_gen_ev) begin
      sto_q <= 1'b0;
    end else if (sw_mask[`SCB_BIT_STOP]) begin
      sto_q <= sw_val[`SCB_BIT_STOP];
    end
  end

  // ack request, read only
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acknowledge_request_flag_q <= 1'b0;
    end else if (BYTE_RX_DONE) begin
      acknowledge_request_flag_q <= 1'b1;
    end else if (ACK_CYCLE_DONE) begin
      acknowledge_request_flag_q <= 1'b0;
    end
  end

  // ack bit; a received byte defaults it to nack until software writes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q <= 1'b0;
    end else if (BYTE_TX_DONE) begin
      ack_q <= ACK_IN;
    end else if (sw_mask[`SCB_BIT_ACK]) begin
      ack_q <= sw_val[`SCB_BIT_ACK];
    end else if (BYTE_RX_DONE) begin
      ack_q <= 1'b0;
    end
  end

  // bus busy between a start and a stop on the wire
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end

  // addressed as slave until the next start or stop
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      addressed_q <= 1'b0;
    end else if (ADDR_MATCH) begin
      addressed_q <= 1'b1;
    end else if (start_det || stop_det) begin
      addressed_q <= 1'b0;
    end
  end

  // an ack cycle finished since our last start; stop waits for it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_seen_q <= 1'b0;
    end else if (start_gen_ev) begin
      ack_seen_q <= 1'b0;
    end else if (ACK_CYCLE_DONE) begin
      ack_seen_q <= 1'b1;
    end
  end

  // condition generator; stop is taken before start so both give stop then start
  always_comb begin
    gen_d = gen_q;
    case (gen_q)
      scb_pkg::G_IDLE: begin
        if (!si_q && sto_q && master_q && ack_seen_q) begin
          gen_d = scb_pkg::G_STOP_LOW;
        end else if (!si_q && sta_q && master_q && ack_seen_q && !sto_q) begin
          gen_d = scb_pkg::G_RS_REL;
        end else if (!si_q && sta_q && !master_q && !busy_q) begin
          gen_d = scb_pkg::G_START_HOLD;
        end
      end
      scb_pkg::G_START_HOLD: if (done) gen_d = scb_pkg::G_IDLE;
      scb_pkg::G_STOP_LOW: if (done) gen_d = scb_pkg::G_STOP_SETUP;
      scb_pkg::G_STOP_SETUP: begin
        if (done) gen_d = scb_s_ok(scl_s, scb_pkg::G_STOP_REL);
      end
      scb_pkg::G_STOP_REL: if (done) gen_d = scb_pkg::G_IDLE;
      scb_pkg::G_RS_REL: if (done) gen_d = scb_pkg::G_RS_SCL;
      scb_pkg::G_RS_SCL: begin
        if (done) gen_d = scb_s_ok(scl_s, scb_pkg::G_START_HOLD);
      end
      default: gen_d = scb_pkg::G_IDLE;
    endcase
  end

  // a clock line held low by another party ends the attempt
  function automatic scb_pkg::scb_gen_e scb_s_ok(input logic scl,
                                                 input scb_pkg::scb_gen_e nxt);
    scb_s_ok = scl ? nxt : scb_pkg::G_IDLE;
  endfunction

  // half bit timer, restarted on every state change
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      gen_q <= scb_pkg::G_IDLE;
      cnt_q <= 11'h000;
    end else begin
      gen_q <= gen_d;
      if (gen_d != gen_q || gen_idle) begin
        cnt_q <= 11'h000;
      end else begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  // line drive per generator state
  always_comb begin
    sda_drv = 1'b0;
    scl_drv = 1'b0;
    case (gen_q)
      scb_pkg::G_START_HOLD: sda_drv = 1'b1;
      scb_pkg::G_STOP_LOW: begin
        sda_drv = 1'b1;
        scl_drv = 1'b1;
      end
      scb_pkg::G_STOP_SETUP: sda_drv = 1'b1;
      scb_pkg::G_RS_REL: scl_drv = 1'b1;
      default: begin
        sda_drv = 1'b0;
        scl_drv = 1'b0;
      end
    endcase
  end

  // pin enables; the shift engine is stalled while the flag is up
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= sda_drv || (gen_idle && SHIFT_SDA_LOW);
      scl_oe_q <= si_q || scl_drv || (gen_idle && SHIFT_SCL_LOW);
    end
  end

  // read data stands one cycle after the strobe; other addresses read zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= `SCB_CTRL_RESET;
    end else if (RD && PAGE == `SCB_CTRL_PAGE && ADDR == `SCB_CTRL_ADDR) begin
      rdata_q <= STATUS;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA = rdata_q;
  assign STATUS = {master_q, transmit_direction_flag_q, sta_q, sto_q, acknowledge_request_flag_q, arbitration_lost_flag_q, ack_q, si_q};
  assign SDA_O = 1'b0;
  assign SCL_O = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign SCL_OE = scl_oe_q;

endmodule // scb_ctrl
`default_nettype wire

// ===== bench/scb_ctrl_monitor.sv
// concurrent checks on the control and status register ports
`default_nettype none
module scb_ctrl_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [7:0] PAGE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic BIT_WR,
  input wire logic [7:0] RDATA,
  // engine events
  input wire logic BYTE_TX_DONE,
  input wire logic ACK_IN,
  input wire logic BYTE_RX_DONE,
  input wire logic ADDR_MATCH,
  // status and clock pin
  input wire logic [7:0] STATUS,
  input wire logic SCL_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic hit;
  // decode seen from the bus side
  assign hit = PAGE == 8'h00 && ADDR == 8'hC0;
  a_int_holds_scl: assert property (STATUS[0] |=> SCL_OE)
    else $error("clock line released while interrupt pending");
  a_read_data: assert property (RD && hit |=> RDATA == $past(STATUS))
    else $error("read data differs from register");
  a_rdata_idle: assert property (!(RD && hit) |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  a_arb_clear: assert property ($fell(STATUS[0]) |-> !STATUS[2])
    else $error("arbitration flag kept after interrupt clear");
  a_start_sticky: assert property (STATUS[5] && !WR && !BIT_WR |=> STATUS[5])
    else $error("start flag cleared without software");
  a_rx_sets: assert property (BYTE_RX_DONE && !BYTE_TX_DONE |=> STATUS[3] && STATUS[0])
    else $error("received byte did not request ack");
  a_tx_ack: assert property (BYTE_TX_DONE |=> STATUS[1] == $past(ACK_IN) && STATUS[0])
    else $error("incoming ack not captured");
  a_addr_start: assert property (ADDR_MATCH |=> STATUS[5] && STATUS[0])
    else $error("address match did not set start and interrupt");
  a_master_rise: assert property ($rose(STATUS[7]) |-> STATUS[6] && STATUS[0])
    else $error("master set without transmit and interrupt");
  a_int_force: assert property (WR && hit && WDATA[0] |=> STATUS[0])
    else $error("forced interrupt not pending");
endmodule // scb_ctrl_monitor

bind scb_ctrl scb_ctrl_monitor mon_u (.CLK, .RST_B, .PAGE, .ADDR, .WDATA, .WR, .RD, .BIT_WR,
  .RDATA, .BYTE_TX_DONE, .ACK_IN, .BYTE_RX_DONE, .ADDR_MATCH, .STATUS, .SCL_OE);
`default_nettype wire

// ===== bench/scb_bus_peer.sv
// another device on the two-wire bus, with the line pull-ups
`default_nettype none
module scb_bus_peer (
  // design pin drivers
  input wire logic SDA_OE,
  input wire logic SCL_OE,
  // resolved lines
  output logic SDA,
  output logic SCL
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_low = 1'b0;
  logic scl_low = 1'b0;
  // open drain: any party pulling low wins, else pull-up
  assign SDA = !(SDA_OE || sda_low);
  assign SCL = !(SCL_OE || scl_low);
  // n link clocks at 160 ns with data low, then a stop; clock idles high after
  task automatic frame_then_stop(input int n);
    #1; // every change then lands clear of the sampling edge
    scl_low = 1'b1;
    #80 sda_low = 1'b1;
    repeat (n) begin
      #80 scl_low = 1'b0;
      #80 scl_low = 1'b1;
    end
    #80 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #80;
  endtask
endmodule // scb_bus_peer
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the control and status register block
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  int n_errors = 0;
  int n_compared = 0;
  integer seed = 32'h7f83;
  logic [7:0] d, m;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic WR = 1'b0, RD = 1'b0, BIT_VAL = 1'b0, BIT_WR = 1'b0, ACK_IN = 1'b0;
  logic [7:0] PAGE = 8'h00, ADDR = 8'h00, WDATA = 8'h00, BIT_ADDR = 8'h00;
  logic [5:0] ev = 6'h00;
  logic drv_one = 1'b0;
  logic [7:0] RDATA, STATUS;
  logic SDA, SCL, SDA_O, SDA_OE, SCL_O, SCL_OE;

  scb_ctrl dut_u (.CLK, .RST_B, .PAGE, .ADDR, .WDATA, .WR, .RD, .BIT_ADDR, .BIT_VAL, .BIT_WR,
    .RDATA, .DATA_WR(ev[5]), .FRAME_START(ev[4]), .BYTE_TX_DONE(ev[3]), .ACK_IN,
    .BYTE_RX_DONE(ev[2]), .ADDR_MATCH(ev[1]), .ACK_CYCLE_DONE(ev[0]), .SDA_DRIVE_ONE(drv_one),
    .SHIFT_SDA_LOW(1'b0), .SHIFT_SCL_LOW(1'b0), .STATUS, .SDA_I(SDA), .SDA_O, .SDA_OE,
    .SCL_I(SCL), .SCL_O, .SCL_OE);
  scb_bus_peer peer_u (.SDA_OE, .SCL_OE, .SDA, .SCL);

  // 200 MHz system clock
  initial begin
    forever #2.5 CLK = ~CLK;
  end

  // byte write and engine event pulses share one cycle, so races can be staged
  task automatic op(input logic [7:0] a, d, input logic w, input logic [5:0] e);
    @(posedge CLK);
    {WR, ADDR, WDATA, ev} <= {w, a, d, e};
    @(posedge CLK);
    {WR, ev} <= 7'h00;
  endtask

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge CLK);
    {BIT_WR, BIT_ADDR, BIT_VAL} <= {1'b1, a, v};
    @(posedge CLK);
    BIT_WR <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic chk(input logic [7:0] pg, a, e, msk);
    @(posedge CLK);
    {RD, PAGE, ADDR} <= {1'b1, pg, a};
    @(posedge CLK);
    {RD, PAGE} <= 9'h000;
    #1 `CHK("rdata", e & msk, RDATA & msk)
  endtask

  task automatic rc(input logic [7:0] e, msk);
    chk(8'h00, 8'hC0, e, msk);
  endtask

  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 5000 && STATUS[b] !== v; i++) @(posedge CLK);
    if (i == 5000) begin
      n_errors++;
      $display("[FAIL] wait on status bit %0d timed out", b);
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence; generator phases are 1000 cycles each, so waits are long
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    rc(8'h00, 8'hFF);
    op(8'hC0, 8'h01, 1, 0);
    chk(8'h01, 8'hC0, 8'h00, 8'hFF);
    chk(8'h00, 8'hC1, 8'h00, 8'hFF);
    op(8'hC1, 8'h00, 1, 0);
    rc(8'h01, 8'hFF);
    // random bytes; start and stop kept clear so nothing launches
    for (int k = 0; k < 8; k++) begin
      d = $random(seed) & 8'hCF;
      op(8'hC0, d, 1, 0);
      m = d & 8'h03;
      rc(m, 8'hFF);
    end
    op(8'hC0, 8'h00, 1, 0);
    bw(8'hC1, 1'b1);
    bw(8'hC7, 1'b1);
    rc(8'h02, 8'hFF);
    @(posedge CLK) ACK_IN <= 1'b1;
    op(8'h00, 8'h00, 0, 6'h04);
    rc(8'h09, 8'hFF);
    op(8'h00, 8'h00, 0, 6'h01);
    rc(8'h01, 8'hFF);
    op(8'hC0, 8'h00, 1, 6'h08);
    rc(8'h03, 8'hFF);
    op(8'hC0, 8'h00, 1, 6'h02);
    rc(8'h21, 8'hFF);
    op(8'hC0, 8'h00, 1, 0);
    rc(8'h00, 8'hFF);
    op(8'h00, 8'h00, 0, 6'h20);
    op(8'h00, 8'h00, 0, 6'h10);
    rc(8'h40, 8'hFF);
    op(8'h00, 8'h00, 0, 6'h10);
    rc(8'h00, 8'hFF);
    // own start, then stop after an ack cycle
    op(8'hC0, 8'h20, 1, 0);
    wait_bit(0, 1'b1);
    rc(8'hE1, 8'hFF);
    op(8'hC0, 8'h10, 1, 0);
    rc(8'hD0, 8'hFF);
    op(8'h00, 8'h00, 0, 6'h01);
    wait_bit(7, 1'b0);
    rc(8'h40, 8'hFF);
    // peer holds the clock low while our stop is generated
    op(8'hC0, 8'h20, 1, 0);
    wait_bit(0, 1'b1);
    op(8'hC0, 8'h10, 1, 0);
    op(8'h00, 8'h00, 0, 6'h01);
    #1 peer_u.scl_low = 1'b1;
    wait_bit(0, 1'b1);
    #1 peer_u.scl_low = 1'b0;
    rc(8'h05, 8'hEF);
    op(8'hC0, 8'h00, 1, 0);
    rc(8'h00, 8'hFF);
    // lost stop left the bus busy; a peer stop frees it and sets nothing here
    peer_u.frame_then_stop(0);
    rc(8'h00, 8'hFF);
    // peer ends the frame with a stop while we are master
    op(8'hC0, 8'h20, 1, 0);
    repeat (4) @(posedge CLK);
    #1 `CHK("sda_start", 1'b1, SDA_OE)
    wait_bit(0, 1'b1);
    op(8'hC0, 8'h00, 1, 0);
    rc(8'hC0, 8'hFF);
    peer_u.frame_then_stop(4);
    wait_bit(0, 1'b1);
    rc(8'h15, 8'hFF);
    // peer pulls data low while the engine sends a one
    op(8'hC0, 8'h00, 1, 0);
    drv_one <= 1'b1;
    #1 peer_u.sda_low = 1'b1;
    wait_bit(0, 1'b1);
    drv_one <= 1'b0;
    rc(8'h05, 8'hFF);
    `CHK("scl_hold", 1'b1, SCL_OE)
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
